/* File: cof_regs.svh */
// Register addresses, field positions, reset values and sizes of the overflow/filter block
`ifndef COF_REGS_SVH
`define COF_REGS_SVH
`define COF_NUM_CNT 29
`define COF_CNT_W 48
`define COF_EVSEL_W 8
`define COF_ADDR_EVSEL_BASE 12'h323
`define COF_ADDR_COUNTER_BASE 12'hb03
`define COF_ADDR_SUMMARY 12'hda0
`define COF_ADDR_MDELEG 12'h303
`define COF_ADDR_MENABLE 12'h304
`define COF_ADDR_MPENDING 12'h344
`define COF_ADDR_SENABLE 12'h104
`define COF_ADDR_SPENDING 12'h144
`define COF_BIT_OVF 63
`define COF_BIT_MACHINE_COUNT_INHIBIT 62
`define COF_BIT_VIRTUAL_USER_COUNT_INHIBIT 58
`define COF_BIT_LCOF 13
`define COF_SUM_LSB 3
`define COF_HAS_S 1'b1
`define COF_HAS_U 1'b1
`define COF_HAS_H 1'b1
`define COF_RST_CNT 48'h0
`define COF_RST_EVSEL 8'h00
`define COF_RST_INH 5'h00
`endif

/* File: cof_pkg.sv */
// Types shared by the overflow/filter block
package cof_pkg;
  typedef enum logic [1:0] {
    COF_PRIV_U = 2'b00,
    COF_PRIV_S = 2'b01,
    COF_PRIV_M = 2'b11
  } cof_priv_t;
endpackage

/* File: cof_overflow_filter.sv */
// Performance counters with mode-based inhibit, sticky overflow flags and overflow interrupt
`timescale 1ns/1ps
`include "cof_regs.svh"

module cof_overflow_filter
  import cof_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Hart state
  input wire logic [1:0] privMode,
  input wire logic virtMode,
  input wire logic [31:0] machCountEnable,
  input wire logic [31:0] hypCountEnable,
  // Event pulses, one per counter 3..31
  input wire logic [`COF_NUM_CNT-1:0] eventIn,
  // Register access port
  input wire logic csrWe,
  input wire logic csrRe,
  input wire logic [11:0] csrAddr,
  input wire logic [63:0] csrWrData,
  output logic [63:0] csrRdData,
  output logic csrRdValid,
  // Interrupt requests towards the trap logic
  output logic mIrq,
  output logic sIrq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  localparam int NC = `COF_NUM_CNT;
  localparam int W = `COF_CNT_W;

  logic [NC-1:0][W-1:0] cnt;
  logic [NC-1:0][W-1:0] next_cnt;
  logic [NC-1:0][`COF_EVSEL_W-1:0] evsel;
  logic [NC-1:0][`COF_EVSEL_W-1:0] next_evsel;
  logic [NC-1:0][4:0] inh;
  logic [NC-1:0][4:0] next_inh;
  logic [NC-1:0] ovf;
  logic [NC-1:0] next_ovf;
  logic [NC-1:0] ovfReq;
  logic lcofPending;
  logic next_lcofPending;
  logic lcofEnable;
  logic next_lcofEnable;
  logic lcofDeleg;
  logic next_lcofDeleg;
  logic [63:0] next_csrRdData;
  logic next_csrRdValid;
  logic next_mIrq;
  logic next_sIrq;

  // Writable inhibit positions; modes the hart lacks keep their bit at zero
  localparam logic [4:0] INH_MASK = {1'b1, `COF_HAS_S, `COF_HAS_U,
                                     `COF_HAS_H & `COF_HAS_S, `COF_HAS_H & `COF_HAS_U};

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Inhibit vector is {machine, supervisor, user, virtual sup, virtual user}
  function automatic logic isInhibited(input logic [4:0] bits, input logic [1:0] mode,
                                       input logic virt);
    logic hit;
    hit = 1'b0;
    case (mode)
      COF_PRIV_M: hit = bits[4];
      COF_PRIV_S: hit = virt ? bits[1] : bits[3];
      COF_PRIV_U: hit = virt ? bits[0] : bits[2];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Per-bit readability of the summary for the current mode
  function automatic logic [31:0] summaryMask(input logic [1:0] mode, input logic virt,
                                              input logic [31:0] men, input logic [31:0] hen);
    logic [31:0] m;
    m = 32'h0;
    if (mode == COF_PRIV_M) begin
      m = 32'hffffffff;
    end else if (mode == COF_PRIV_S && !virt) begin
      m = men;
    end else if (mode == COF_PRIV_S && virt) begin
      m = men & hen;
    end
    return m;
  endfunction

  // Counter slot i answers at the counter base plus i; shared by write and read paths
  function automatic logic isCounterAddr(input logic [11:0] addr, input int slot);
    logic hit;
    hit = (addr == `COF_ADDR_COUNTER_BASE + 12'(slot));
    return hit;
  endfunction

  // Selector slot i answers at the selector base plus i
  function automatic logic isSelectorAddr(input logic [11:0] addr, input int slot);
    logic hit;
    hit = (addr == `COF_ADDR_EVSEL_BASE + 12'(slot));
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Counters, selectors and overflow flags

  always_comb begin
    logic [W:0] sum;
    logic carry;
    sum = '0;
    carry = 1'b0;
    next_cnt = cnt;
    next_evsel = evsel;
    next_inh = inh;
    next_ovf = ovf;
    ovfReq = '0;
    for (int i = 0; i < NC; i++) begin
      sum = {1'b0, cnt[i]} + {{W{1'b0}}, 1'b1};
      carry = 1'b0;
      if (eventIn[i] && !isInhibited(inh[i], privMode, virtMode)) begin
        next_cnt[i] = sum[W-1:0]; // wraps to zero
        carry = sum[W];
      end
      // A software write replaces the increment and never counts as overflow
      if (csrWe && isCounterAddr(csrAddr, i)) begin
        next_cnt[i] = csrWrData[W-1:0];
        carry = 1'b0;
      end
      if (csrWe && isSelectorAddr(csrAddr, i)) begin
        next_evsel[i] = csrWrData[`COF_EVSEL_W-1:0];
        next_inh[i] = csrWrData[`COF_BIT_MACHINE_COUNT_INHIBIT:`COF_BIT_VIRTUAL_USER_COUNT_INHIBIT] & INH_MASK;
        next_ovf[i] = csrWrData[`COF_BIT_OVF];
      end
      // Overflow wins over a same-cycle software clear so no event is lost
      if (carry) begin
        ovfReq[i] = !ovf[i];
        next_ovf[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NC; i++) begin
        cnt[i] <= `COF_RST_CNT;
        evsel[i] <= `COF_RST_EVSEL;
        inh[i] <= `COF_RST_INH;
      end
      ovf <= '0;
    end else begin
      cnt <= next_cnt;
      evsel <= next_evsel;
      inh <= next_inh;
      ovf <= next_ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Local overflow interrupt: pending, enable, delegation

  logic wrDeleg;
  logic wrMEnable;
  logic wrMPending;
  logic wrSEnable;
  logic wrSPending;

  // One strobe per interrupt register; the supervisor aliases only take a write
  // once the interrupt is delegated, so an undelegated request stays machine-private
  always_comb begin
    wrDeleg = 1'b0;
    wrMEnable = 1'b0;
    wrMPending = 1'b0;
    wrSEnable = 1'b0;
    wrSPending = 1'b0;
    if (csrWe) begin
      if (csrAddr == `COF_ADDR_MDELEG) begin
        wrDeleg = 1'b1;
      end else if (csrAddr == `COF_ADDR_MENABLE) begin
        wrMEnable = 1'b1;
      end else if (csrAddr == `COF_ADDR_MPENDING) begin
        wrMPending = 1'b1;
      end else if (csrAddr == `COF_ADDR_SENABLE) begin
        wrSEnable = lcofDeleg;
      end else if (csrAddr == `COF_ADDR_SPENDING) begin
        wrSPending = lcofDeleg;
      end
    end
  end

  // Next pending, enable and delegation bits; only bit 13 is kept in each register
  always_comb begin
    next_lcofPending = lcofPending;
    next_lcofEnable = lcofEnable;
    next_lcofDeleg = lcofDeleg;
    if (wrMPending || wrSPending) begin
      next_lcofPending = csrWrData[`COF_BIT_LCOF];
    end
    if (wrMEnable || wrSEnable) begin
      next_lcofEnable = csrWrData[`COF_BIT_LCOF];
    end
    if (wrDeleg) begin
      next_lcofDeleg = csrWrData[`COF_BIT_LCOF] & `COF_HAS_S;
    end
    // Pending sets on the same edge as the flag and beats a same-cycle software clear,
    // so an overflow that races the handler's clear is never lost
    if (|ovfReq) begin
      next_lcofPending = 1'b1;
    end
    // Routed from registered state, so the request trails pending by a cycle
    next_mIrq = lcofPending && lcofEnable && !lcofDeleg;
    next_sIrq = lcofPending && lcofEnable && lcofDeleg;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lcofPending <= 1'b0;
      lcofEnable <= 1'b0;
      lcofDeleg <= 1'b0;
      mIrq <= 1'b0;
      sIrq <= 1'b0;
    end else begin
      lcofPending <= next_lcofPending;
      lcofEnable <= next_lcofEnable;
      lcofDeleg <= next_lcofDeleg;
      mIrq <= next_mIrq;
      sIrq <= next_sIrq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path, registered for timing; unmapped addresses read zero

  always_comb begin
    logic [31:0] summary;
    summary = '0;
    summary[`COF_SUM_LSB +: NC] = ovf; // bits 0..2 have no flag
    summary = summary & summaryMask(privMode, virtMode, machCountEnable, hypCountEnable);
    next_csrRdData = 64'h0;
    next_csrRdValid = csrRe;
    if (csrRe) begin
      if (csrAddr == `COF_ADDR_SUMMARY && `COF_HAS_S) begin
        next_csrRdData = {32'h0, summary};
      end else if (csrAddr == `COF_ADDR_MPENDING || csrAddr == `COF_ADDR_SPENDING) begin
        next_csrRdData[`COF_BIT_LCOF] = lcofPending &&
                                        (csrAddr == `COF_ADDR_MPENDING || lcofDeleg);
      end else if (csrAddr == `COF_ADDR_MENABLE || csrAddr == `COF_ADDR_SENABLE) begin
        next_csrRdData[`COF_BIT_LCOF] = lcofEnable &&
                                        (csrAddr == `COF_ADDR_MENABLE || lcofDeleg);
      end else if (csrAddr == `COF_ADDR_MDELEG) begin
        next_csrRdData[`COF_BIT_LCOF] = lcofDeleg;
      end else begin
        for (int i = 0; i < NC; i++) begin
          if (isCounterAddr(csrAddr, i)) begin
            next_csrRdData = {{(64-W){1'b0}}, cnt[i]};
          end else if (isSelectorAddr(csrAddr, i)) begin
            // Reserved bits 57:56 and the unused select bits read zero
            next_csrRdData[`COF_BIT_OVF] = ovf[i];
            next_csrRdData[`COF_BIT_MACHINE_COUNT_INHIBIT:`COF_BIT_VIRTUAL_USER_COUNT_INHIBIT] = inh[i];
            next_csrRdData[`COF_EVSEL_W-1:0] = evsel[i];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      csrRdData <= 64'h0;
      csrRdValid <= 1'b0;
    end else begin
      csrRdData <= next_csrRdData;
      csrRdValid <= next_csrRdValid;
    end
  end

endmodule

/* File: cof_overflow_filter_asserts.sv */
// Port-level checks of the overflow/filter block
`timescale 1ns/1ps
`include "cof_regs.svh"
module cof_overflow_filter_asserts
  import cof_pkg::*;
(
  // Clock, reset and hart state
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] privMode,
  input wire logic virtMode,
  input wire logic [31:0] machCountEnable,
  input wire logic [31:0] hypCountEnable,
  input wire logic [`COF_NUM_CNT-1:0] eventIn,
  // Register port and requests
  input wire logic csrWe,
  input wire logic csrRe,
  input wire logic [11:0] csrAddr,
  input wire logic [63:0] csrWrData,
  input wire logic [63:0] csrRdData,
  input wire logic csrRdValid,
  input wire logic mIrq,
  input wire logic sIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Summary read request
  logic isSum;
  assign isSum = csrRe && csrAddr == `COF_ADDR_SUMMARY;
  ////////////////////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (csrRe |=> csrRdValid) else $error("read not answered");
  rd_idle_a: assert property (!csrRdValid |-> csrRdData == 64'h0) else $error("idle data");
  sum_width_a: assert property (isSum |=> csrRdData[63:32] == 32'h0) else $error("sum hi");
  sum_low_a: assert property (isSum |=> csrRdData[2:0] == 3'h0) else $error("sum lo");
  sum_user_a: assert property (isSum && privMode == COF_PRIV_U |=> csrRdData == 64'h0)
    else $error("sum in user");
  sum_smask_a: assert property (isSum && privMode == COF_PRIV_S && !virtMode
    |=> (csrRdData[31:0] & ~$past(machCountEnable)) == 32'h0) else $error("sum s mask");
  sum_vsmask_a: assert property (isSum && privMode == COF_PRIV_S && virtMode
    |=> (csrRdData[31:0] & ~($past(machCountEnable) & $past(hypCountEnable))) == 32'h0)
    else $error("sum vs mask");
  irq_route_a: assert property (!(mIrq && sIrq)) else $error("both requests");
  // Main scenarios
  cover property (mIrq);
  cover property (sIrq);
  cover property (csrRdValid && csrRdData[63]);
endmodule

/* File: cof_hart_model.sv */
// Hart-side model: privilege mode and event pulses
`timescale 1ns/1ps
`include "cof_regs.svh"
module cof_hart_model
  import cof_pkg::*;
(
  // Requests from the bench
  input wire logic [2:0] modeCode,
  input wire logic evStrobe,
  input wire logic [4:0] evIdx,
  // Towards the block
  output logic [1:0] privMode,
  output logic virtMode,
  output logic [`COF_NUM_CNT-1:0] eventIn
);
  // Codes 0..4 are M, S, U, VS, VU; one lane a pulse keeps counts easy to predict
  always_comb begin
    privMode = (modeCode == 3'h0) ? COF_PRIV_M : (modeCode[0] ? COF_PRIV_S : COF_PRIV_U);
    virtMode = modeCode > 3'h2;
    eventIn = evStrobe ? (`COF_NUM_CNT'(1) << evIdx) : '0;
  end
endmodule

/* File: counter_overflow_mode_filter_tb_top.sv */
// Self-checking bench of the overflow/filter block
`timescale 1ns/1ps
`include "cof_regs.svh"
module counter_overflow_mode_filter_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] modeCode = 3'h0;
  logic evStrobe = 1'b0;
  logic [4:0] evIdx = 5'h0;
  logic [1:0] privMode;
  logic virtMode;
  logic [`COF_NUM_CNT-1:0] eventIn;
  logic [31:0] machCountEnable = 32'h0;
  logic [31:0] hypCountEnable = 32'h0;
  logic csrWe = 1'b0;
  logic csrRe = 1'b0;
  logic [11:0] csrAddr = 12'h0;
  logic [63:0] csrWrData = 64'h0;
  logic [63:0] csrRdData;
  logic csrRdValid, mIrq, sIrq;
  logic [63:0] expQ[$];
  logic [31:0] seed = 32'h21dc;
  logic [4:0] idx;
  logic [7:0] evs;
  logic [11:0] sel, cnt;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  cof_hart_model i_hart (.modeCode(modeCode), .evStrobe(evStrobe), .evIdx(evIdx),
    .privMode(privMode), .virtMode(virtMode), .eventIn(eventIn));
  cof_overflow_filter i_dut (.ref_clk(ref_clk), .rstn(rstn), .privMode(privMode),
    .virtMode(virtMode), .machCountEnable(machCountEnable), .hypCountEnable(hypCountEnable),
    .eventIn(eventIn), .csrWe(csrWe), .csrRe(csrRe), .csrAddr(csrAddr),
    .csrWrData(csrWrData), .csrRdData(csrRdData), .csrRdValid(csrRdValid),
    .mIrq(mIrq), .sIrq(sIrq));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] got);
    checks++;
    if (got !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One edge, then settle 1 ns past it so inputs never move on the sampling edge
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  // Strobes drop for a full cycle between accesses, never reassigned in one step
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    csrWe = 1'b1;
    csrAddr = a;
    csrWrData = d;
    step();
    csrWe = 1'b0;
    step();
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    csrRe = 1'b1;
    csrAddr = a;
    expQ.push_back(e);
    step();
    csrRe = 1'b0;
    step();
  endtask
  task automatic ev(input logic [2:0] m, input logic [4:0] i);
    modeCode = m;
    evIdx = i;
    evStrobe = 1'b1;
    step();
    evStrobe = 1'b0;
    step();
  endtask
  // Read answers are matched against the oldest note; a hang ends as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (csrRdValid === 1'b1) chk("csrRdData", expQ.pop_front(), csrRdData);
    if (cycles == 2000) begin
      n_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
    step();
    // Each inhibit bit blocks its own mode and leaves the next mode counting
    for (int k = 0; k < 5; k++) begin
      wr(12'h323, 64'h1 << (62 - k));
      wr(12'hb03, 64'h0);
      rd(12'h323, 64'h1 << (62 - k));
      ev(3'(k), 5'h0);
      ev(3'((k + 1) % 5), 5'h0);
      rd(12'hb03, 64'h1);
    end
    wr(12'h323, 64'h0);
    wr(12'hb03, 64'h0);
    for (int k = 0; k < 5; k++) ev(3'(k), 5'h0);
    rd(12'hb03, 64'h5);
    // Overflow of a random counter with enable set
    seed = xs(seed);
    idx = 5'(seed % 32'd29);
    evs = seed[15:8];
    sel = 12'h323 + 12'(idx);
    cnt = 12'hb03 + 12'(idx);
    wr(12'h304, 64'h2000);
    wr(sel, {56'h0, evs});
    wr(cnt, 64'hffff_ffff_ffff);
    wr(cnt, 64'h0);
    wr(cnt, 64'hffff_ffff_ffff);
    rd(12'h344, 64'h0);
    rd(sel, {56'h0, evs});
    ev(3'h0, idx);
    repeat (2) step();
    chk("mIrq", 64'h1, 64'(mIrq));
    rd(12'h344, 64'h2000);
    rd(sel, {1'b1, 55'h0, evs});
    rd(12'hda0, 64'h8 << idx);
    ev(3'h0, idx);
    rd(cnt, 64'h1);
    // Summary gating by the enable masks
    machCountEnable = xs(seed);
    hypCountEnable = xs(machCountEnable);
    modeCode = 3'h1;
    rd(12'hda0, (64'h8 << idx) & {32'h0, machCountEnable});
    modeCode = 3'h3;
    rd(12'hda0, (64'h8 << idx) & {32'h0, machCountEnable & hypCountEnable});
    // Second overflow with the flag still set raises nothing
    wr(12'h344, 64'h0);
    wr(cnt, 64'hffff_ffff_ffff);
    ev(3'h0, idx);
    repeat (2) step();
    rd(12'h344, 64'h0);
    chk("mIrq", 64'h0, 64'(mIrq));
    // Re-armed counter, delegated request
    wr(sel, {56'h0, evs});
    wr(cnt, 64'hffff_ffff_ffff);
    wr(12'h303, 64'h2000);
    ev(3'h2, idx);
    repeat (2) step();
    chk("sIrq", 64'h1, 64'(sIrq));
    chk("mIrq", 64'h0, 64'(mIrq));
    rd(12'h144, 64'h2000);
    rd(12'h000, 64'h0);
    repeat (2) step();
    print_verdict();
  end
endmodule
bind cof_overflow_filter cof_overflow_filter_asserts i_chk (.ref_clk(ref_clk), .rstn(rstn),
  .privMode(privMode), .virtMode(virtMode), .machCountEnable(machCountEnable),
  .hypCountEnable(hypCountEnable), .eventIn(eventIn), .csrWe(csrWe), .csrRe(csrRe),
  .csrAddr(csrAddr), .csrWrData(csrWrData), .csrRdData(csrRdData),
  .csrRdValid(csrRdValid), .mIrq(mIrq), .sIrq(sIrq));
